// File: hbspwm_regs.vh
// Register map, field positions and reset values for the H-bridge PWM pair
`ifndef HBSPWM_REGS_VH
`define HBSPWM_REGS_VH
// Register offsets (byte addresses, one word each)
`define HBSPWM_MASTER_CONTROL_REG 8'h00
`define HBSPWM_OUTPUT_ENABLE_REG 8'h04
`define HBSPWM_IRQ_STATUS_REG 8'h08
`define HBSPWM_IRQ_DMA_ENABLE_REG 8'h0c
`define HBSPWM_UNIT_B_BASE 8'h20
`define HBSPWM_UNIT_C_BASE 8'h40
// Offsets inside a unit window
`define HBSPWM_UNIT_CONTROL_REG 8'h00
`define HBSPWM_PERIOD_RELOAD_REG 8'h04
`define HBSPWM_COMPARE_A_VALUE 8'h08
`define HBSPWM_COMPARE_B_VALUE 8'h0c
`define HBSPWM_DEADTIME_REG 8'h10
// Master control fields
`define HBSPWM_UNIT_B_COUNT_ENABLE 0
`define HBSPWM_UNIT_C_COUNT_ENABLE 1
`define HBSPWM_UNIT_B_SOFT_UPDATE 2
`define HBSPWM_UNIT_C_SOFT_UPDATE 3
// Output enable fields
`define HBSPWM_UNIT_B_OUT_A_ENABLE 0
`define HBSPWM_UNIT_B_OUT_B_ENABLE 1
`define HBSPWM_UNIT_C_OUT_A_ENABLE 2
`define HBSPWM_UNIT_C_OUT_B_ENABLE 3
// Interrupt status / enable fields (reset events)
`define HBSPWM_UNIT_B_RESET_IRQ 0
`define HBSPWM_UNIT_C_RESET_IRQ 1
// Unit control fields
`define HBSPWM_CONTINUOUS_SELECT 0
`define HBSPWM_SHADOW_ENABLE 1
`define HBSPWM_UPDATE_ON_COUNTER_RESET 2
`define HBSPWM_DEADTIME_ENABLE 3
// Dead-time register fields
`define HBSPWM_RISING_DT_LSB 0
`define HBSPWM_FALLING_DT_LSB 16
// Reset values
`define HBSPWM_PERIOD_RESET 16'hffff
`define HBSPWM_COMPARE_RESET 16'h0000
`define HBSPWM_UNIT_CONTROL_RESET 4'h1
`define HBSPWM_DEADTIME_RESET 9'h000
`endif

// File: hbspwm_unit.v
// One timer unit: counter, shadowed compares, set/clear output, dead-time pair
`timescale 1ns/1ns
`include "hbspwm_regs.vh"
module hbspwm_unit #(
   parameter WIDTH = 16,
   parameter DT_WIDTH = 9
) (
   // Clock and reset
   input wire i_clock,
   input wire i_rst_b,
   // Control
   input wire i_count_enable,
   input wire i_soft_update,
   input wire i_continuous_select,
   input wire i_shadow_enable,
   input wire i_update_on_counter_reset,
   input wire i_deadtime_enable,
   input wire [DT_WIDTH-1:0] i_rising_deadtime_count,
   input wire [DT_WIDTH-1:0] i_falling_deadtime_count,
   // Shadow register writes
   input wire i_period_write,
   input wire i_compare_a_write,
   input wire i_compare_b_write,
   input wire [WIDTH-1:0] i_write_data,
   // Status and outputs
   output reg [WIDTH-1:0] o_counter,
   output reg [WIDTH-1:0] o_period_shadow,
   output reg [WIDTH-1:0] o_compare_a_shadow,
   output reg [WIDTH-1:0] o_compare_b_shadow,
   output wire o_counter_reset,
   output reg o_output_primary,
   output reg o_output_complement
);
   reg [WIDTH-1:0] period_active;
   reg [WIDTH-1:0] compare_a_active;
   reg [WIDTH-1:0] compare_b_active;
   reg [DT_WIDTH-1:0] dt_count;
   reg ref_level;
   reg ref_last;
   wire update_event;

   assign o_counter_reset = i_count_enable && (o_counter == period_active);
   assign update_event = i_soft_update || (i_update_on_counter_reset && o_counter_reset);

   // continuous count; one-shot holds at period when not continuous
   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_counter <= {WIDTH{1'b0}};
      end else if (!i_count_enable) begin
         o_counter <= o_counter;
      end else if (o_counter_reset) begin
         if (i_continuous_select) begin
            o_counter <= {WIDTH{1'b0}};
         end
      end else begin
         o_counter <= o_counter + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_period_shadow <= `HBSPWM_PERIOD_RESET;
         o_compare_a_shadow <= `HBSPWM_COMPARE_RESET;
         o_compare_b_shadow <= `HBSPWM_COMPARE_RESET;
      end else begin
         if (i_period_write) o_period_shadow <= i_write_data;
         if (i_compare_a_write) o_compare_a_shadow <= i_write_data;
         if (i_compare_b_write) o_compare_b_shadow <= i_write_data;
      end
   end

   // active load; without shadowing writes go straight through
   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         period_active <= `HBSPWM_PERIOD_RESET;
         compare_a_active <= `HBSPWM_COMPARE_RESET;
         compare_b_active <= `HBSPWM_COMPARE_RESET;
      end else if (!i_shadow_enable) begin
         if (i_period_write) period_active <= i_write_data;
         if (i_compare_a_write) compare_a_active <= i_write_data;
         if (i_compare_b_write) compare_b_active <= i_write_data;
      end else if (update_event) begin
         period_active <= o_period_shadow;
         compare_a_active <= o_compare_a_shadow;
         compare_b_active <= o_compare_b_shadow;
      end
   end

   // Reference waveform; clear wins if both compares equal
   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         ref_level <= 1'b0;
      end else if (i_count_enable) begin
         if (o_counter == compare_b_active) begin
            ref_level <= 1'b0;
         end else if (o_counter == compare_a_active) begin
            ref_level <= 1'b1;
         end
      end
   end

   // dead-time counter restarts on every reference edge
   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         ref_last <= 1'b0;
         dt_count <= {DT_WIDTH{1'b0}};
      end else begin
         ref_last <= ref_level;
         if (ref_level != ref_last) begin
            dt_count <= ref_level ? i_rising_deadtime_count : i_falling_deadtime_count;
         end else if (dt_count != {DT_WIDTH{1'b0}}) begin
            dt_count <= dt_count - {{(DT_WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

   // complement pair with gap; both idle inside the dead band
   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_output_primary <= 1'b0;
         o_output_complement <= 1'b0;
      end else if (!i_deadtime_enable) begin
         o_output_primary <= ref_level;
         o_output_complement <= 1'b0;
      end else if ((ref_level != ref_last) || (dt_count != {DT_WIDTH{1'b0}})) begin
         o_output_primary <= 1'b0;
         o_output_complement <= 1'b0;
      end else begin
         o_output_primary <= ref_level;
         o_output_complement <= ~ref_level;
      end
   end
endmodule // hbspwm_unit

// File: hbspwm_pair.v
// Top of the H-bridge unipolar PWM pair: register port, two units, enables, interrupt
`timescale 1ns/1ns
`include "hbspwm_regs.vh"
module hbspwm_pair #(
   parameter WIDTH = 16,
   parameter DT_WIDTH = 9
) (
   // Clock and reset
   input wire i_clock,
   input wire i_rst_b,
   // Register port
   input wire [7:0] i_addr,
   input wire [31:0] i_wdata,
   input wire i_write,
   input wire i_read,
   output reg [31:0] o_rdata,
   // Gate driver pins
   output wire o_unit_b_output_primary,
   output wire o_unit_b_output_complement,
   output wire o_unit_c_output_primary,
   output wire o_unit_c_output_complement,
   output wire o_unit_b_output_primary_oe_b,
   output wire o_unit_b_output_complement_oe_b,
   output wire o_unit_c_output_primary_oe_b,
   output wire o_unit_c_output_complement_oe_b,
   // Interrupt
   output wire o_unit_b_irq_line
);
   reg [1:0] count_enable;
   reg [3:0] output_enable_reg;
   reg [1:0] irq_status;
   reg [1:0] irq_dma_enable_reg;
   reg [3:0] unit_control_reg_b;
   reg [3:0] unit_control_reg_c;
   reg [DT_WIDTH-1:0] rising_deadtime_count_b;
   reg [DT_WIDTH-1:0] falling_deadtime_count_b;
   reg [DT_WIDTH-1:0] rising_deadtime_count_c;
   reg [DT_WIDTH-1:0] falling_deadtime_count_c;
   reg [31:0] next_rdata;
   wire master_write;
   wire [1:0] soft_update;
   wire [1:0] counter_reset;
   wire [WIDTH-1:0] counter_b;
   wire [WIDTH-1:0] counter_c;
   wire [WIDTH-1:0] period_b;
   wire [WIDTH-1:0] period_c;
   wire [WIDTH-1:0] cmp_a_b;
   wire [WIDTH-1:0] cmp_a_c;
   wire [WIDTH-1:0] cmp_b_b;
   wire [WIDTH-1:0] cmp_b_c;
   wire [3:0] raw_out;
   wire b_sel;
   wire c_sel;
   wire [7:0] unit_off;

   // Unit window decode
   assign b_sel = (i_addr & 8'he0) == `HBSPWM_UNIT_B_BASE;
   assign c_sel = (i_addr & 8'he0) == `HBSPWM_UNIT_C_BASE;
   assign unit_off = i_addr & 8'h1f;
   assign master_write = i_write && (i_addr == `HBSPWM_MASTER_CONTROL_REG);
   // soft update bits are self-clearing pulses
   assign soft_update[0] = master_write && i_wdata[`HBSPWM_UNIT_B_SOFT_UPDATE];
   assign soft_update[1] = master_write && i_wdata[`HBSPWM_UNIT_C_SOFT_UPDATE];

   // Control register writes
   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         count_enable <= 2'h0;
         output_enable_reg <= 4'h0;
         irq_dma_enable_reg <= 2'h0;
         unit_control_reg_b <= `HBSPWM_UNIT_CONTROL_RESET;
         unit_control_reg_c <= `HBSPWM_UNIT_CONTROL_RESET;
         rising_deadtime_count_b <= `HBSPWM_DEADTIME_RESET;
         falling_deadtime_count_b <= `HBSPWM_DEADTIME_RESET;
         rising_deadtime_count_c <= `HBSPWM_DEADTIME_RESET;
         falling_deadtime_count_c <= `HBSPWM_DEADTIME_RESET;
      end else if (i_write) begin
         if (i_addr == `HBSPWM_MASTER_CONTROL_REG) begin
            count_enable[0] <= i_wdata[`HBSPWM_UNIT_B_COUNT_ENABLE];
            count_enable[1] <= i_wdata[`HBSPWM_UNIT_C_COUNT_ENABLE];
         end else if (i_addr == `HBSPWM_OUTPUT_ENABLE_REG) begin
            output_enable_reg <= i_wdata[3:0];
         end else if (i_addr == `HBSPWM_IRQ_DMA_ENABLE_REG) begin
            irq_dma_enable_reg <= i_wdata[1:0];
         end else if (b_sel && unit_off == `HBSPWM_UNIT_CONTROL_REG) begin
            unit_control_reg_b <= i_wdata[3:0];
         end else if (c_sel && unit_off == `HBSPWM_UNIT_CONTROL_REG) begin
            unit_control_reg_c <= i_wdata[3:0];
         end else if (b_sel && unit_off == `HBSPWM_DEADTIME_REG) begin
            rising_deadtime_count_b <= i_wdata[`HBSPWM_RISING_DT_LSB +: DT_WIDTH];
            falling_deadtime_count_b <= i_wdata[`HBSPWM_FALLING_DT_LSB +: DT_WIDTH];
         end else if (c_sel && unit_off == `HBSPWM_DEADTIME_REG) begin
            rising_deadtime_count_c <= i_wdata[`HBSPWM_RISING_DT_LSB +: DT_WIDTH];
            falling_deadtime_count_c <= i_wdata[`HBSPWM_FALLING_DT_LSB +: DT_WIDTH];
         end
      end
   end

   // sticky reset events, write one to clear, set wins
   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         irq_status <= 2'h0;
      end else if (i_write && i_addr == `HBSPWM_IRQ_STATUS_REG) begin
         irq_status <= (irq_status & ~i_wdata[1:0]) | counter_reset;
      end else begin
         irq_status <= irq_status | counter_reset;
      end
   end

   assign o_unit_b_irq_line = |(irq_status & irq_dma_enable_reg);

   // Read mux; unmapped addresses read zero
   always @* begin
      next_rdata = 32'h0000_0000;
      if (i_addr == `HBSPWM_MASTER_CONTROL_REG) begin
         next_rdata[1:0] = count_enable;
      end else if (i_addr == `HBSPWM_OUTPUT_ENABLE_REG) begin
         next_rdata[3:0] = output_enable_reg;
      end else if (i_addr == `HBSPWM_IRQ_STATUS_REG) begin
         next_rdata[1:0] = irq_status;
      end else if (i_addr == `HBSPWM_IRQ_DMA_ENABLE_REG) begin
         next_rdata[1:0] = irq_dma_enable_reg;
      end else if (b_sel || c_sel) begin
         if (unit_off == `HBSPWM_UNIT_CONTROL_REG) begin
            next_rdata[3:0] = b_sel ? unit_control_reg_b : unit_control_reg_c;
            // Live counter in upper half
            next_rdata[16 +: WIDTH] = b_sel ? counter_b : counter_c;
         end else if (unit_off == `HBSPWM_PERIOD_RELOAD_REG) begin
            next_rdata[WIDTH-1:0] = b_sel ? period_b : period_c;
         end else if (unit_off == `HBSPWM_COMPARE_A_VALUE) begin
            next_rdata[WIDTH-1:0] = b_sel ? cmp_a_b : cmp_a_c;
         end else if (unit_off == `HBSPWM_COMPARE_B_VALUE) begin
            next_rdata[WIDTH-1:0] = b_sel ? cmp_b_b : cmp_b_c;
         end else if (unit_off == `HBSPWM_DEADTIME_REG) begin
            next_rdata[`HBSPWM_RISING_DT_LSB +: DT_WIDTH] =
               b_sel ? rising_deadtime_count_b : rising_deadtime_count_c;
            next_rdata[`HBSPWM_FALLING_DT_LSB +: DT_WIDTH] =
               b_sel ? falling_deadtime_count_b : falling_deadtime_count_c;
         end
      end
   end

   // Read data stands one cycle after the strobe only
   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_read) begin
         o_rdata <= next_rdata;
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end

   // Unit B: fast leg in the positive half line
   hbspwm_unit #(.WIDTH(WIDTH), .DT_WIDTH(DT_WIDTH)) u_timer_unit_b (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_count_enable(count_enable[0]),
      .i_soft_update(soft_update[0]),
      .i_continuous_select(unit_control_reg_b[`HBSPWM_CONTINUOUS_SELECT]),
      .i_shadow_enable(unit_control_reg_b[`HBSPWM_SHADOW_ENABLE]),
      .i_update_on_counter_reset(unit_control_reg_b[`HBSPWM_UPDATE_ON_COUNTER_RESET]),
      .i_deadtime_enable(unit_control_reg_b[`HBSPWM_DEADTIME_ENABLE]),
      .i_rising_deadtime_count(rising_deadtime_count_b),
      .i_falling_deadtime_count(falling_deadtime_count_b),
      .i_period_write(i_write && b_sel && unit_off == `HBSPWM_PERIOD_RELOAD_REG),
      .i_compare_a_write(i_write && b_sel && unit_off == `HBSPWM_COMPARE_A_VALUE),
      .i_compare_b_write(i_write && b_sel && unit_off == `HBSPWM_COMPARE_B_VALUE),
      .i_write_data(i_wdata[WIDTH-1:0]),
      .o_counter(counter_b),
      .o_period_shadow(period_b),
      .o_compare_a_shadow(cmp_a_b),
      .o_compare_b_shadow(cmp_b_b),
      .o_counter_reset(counter_reset[0]),
      .o_output_primary(raw_out[0]),
      .o_output_complement(raw_out[1])
   );

   // Unit C: fast leg in the negative half line
   hbspwm_unit #(.WIDTH(WIDTH), .DT_WIDTH(DT_WIDTH)) u_timer_unit_c (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_count_enable(count_enable[1]),
      .i_soft_update(soft_update[1]),
      .i_continuous_select(unit_control_reg_c[`HBSPWM_CONTINUOUS_SELECT]),
      .i_shadow_enable(unit_control_reg_c[`HBSPWM_SHADOW_ENABLE]),
      .i_update_on_counter_reset(unit_control_reg_c[`HBSPWM_UPDATE_ON_COUNTER_RESET]),
      .i_deadtime_enable(unit_control_reg_c[`HBSPWM_DEADTIME_ENABLE]),
      .i_rising_deadtime_count(rising_deadtime_count_c),
      .i_falling_deadtime_count(falling_deadtime_count_c),
      .i_period_write(i_write && c_sel && unit_off == `HBSPWM_PERIOD_RELOAD_REG),
      .i_compare_a_write(i_write && c_sel && unit_off == `HBSPWM_COMPARE_A_VALUE),
      .i_compare_b_write(i_write && c_sel && unit_off == `HBSPWM_COMPARE_B_VALUE),
      .i_write_data(i_wdata[WIDTH-1:0]),
      .o_counter(counter_c),
      .o_period_shadow(period_c),
      .o_compare_a_shadow(cmp_a_c),
      .o_compare_b_shadow(cmp_b_c),
      .o_counter_reset(counter_reset[1]),
      .o_output_primary(raw_out[2]),
      .o_output_complement(raw_out[3])
   );

   // pins driven only when enabled; disabled pins float and read low
   assign o_unit_b_output_primary = raw_out[0] & output_enable_reg[`HBSPWM_UNIT_B_OUT_A_ENABLE];
   assign o_unit_b_output_complement = raw_out[1] & output_enable_reg[`HBSPWM_UNIT_B_OUT_B_ENABLE];
   assign o_unit_c_output_primary = raw_out[2] & output_enable_reg[`HBSPWM_UNIT_C_OUT_A_ENABLE];
   assign o_unit_c_output_complement = raw_out[3] & output_enable_reg[`HBSPWM_UNIT_C_OUT_B_ENABLE];
   assign o_unit_b_output_primary_oe_b = ~output_enable_reg[`HBSPWM_UNIT_B_OUT_A_ENABLE];
   assign o_unit_b_output_complement_oe_b = ~output_enable_reg[`HBSPWM_UNIT_B_OUT_B_ENABLE];
   assign o_unit_c_output_primary_oe_b = ~output_enable_reg[`HBSPWM_UNIT_C_OUT_A_ENABLE];
   assign o_unit_c_output_complement_oe_b = ~output_enable_reg[`HBSPWM_UNIT_C_OUT_B_ENABLE];
endmodule // hbspwm_pair

// File: hbspwm_pair_properties.sv
// Port-level assertions for the H-bridge PWM pair
`timescale 1ns/1ns
module hbspwm_pair_properties (
   // Clock and reset
   input logic i_clock,
   input logic i_rst_b,
   // Register port
   input logic [7:0] i_addr,
   input logic [31:0] i_wdata,
   input logic i_write,
   input logic i_read,
   input logic [31:0] o_rdata,
   // Gate pins and interrupt
   input logic o_unit_b_output_primary,
   input logic o_unit_b_output_complement,
   input logic o_unit_c_output_primary,
   input logic o_unit_c_output_complement,
   input logic o_unit_b_output_primary_oe_b,
   input logic o_unit_b_output_complement_oe_b,
   input logic o_unit_c_output_primary_oe_b,
   input logic o_unit_c_output_complement_oe_b,
   input logic o_unit_b_irq_line
);
   wire [3:0] lvl = {o_unit_c_output_complement, o_unit_c_output_primary,
      o_unit_b_output_complement, o_unit_b_output_primary};
   wire [3:0] oe_bits = {o_unit_c_output_complement_oe_b, o_unit_c_output_primary_oe_b,
      o_unit_b_output_complement_oe_b, o_unit_b_output_primary_oe_b};
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   // A shorted leg would shoot through the bridge
   AST_LEG_B_APART: assert property (!(lvl[0] && lvl[1]))
      else $error("unit b leg driven high on both sides");
   AST_LEG_C_APART: assert property (!(lvl[2] && lvl[3]))
      else $error("unit c leg driven high on both sides");
   AST_GAP_BEFORE_COMP: assert property ($rose(lvl[3]) |-> !$past(lvl[2]))
      else $error("unit c complement rose without a dead gap");
   AST_PIN_ENABLE_WRITE: assert property (i_write && i_addr == 8'h04 |=> oe_bits == ~$past(i_wdata[3:0]))
      else $error("pin enables do not follow the written bits");
   AST_DISABLED_PIN_LOW: assert property ((lvl & oe_bits) == 4'h0)
      else $error("disabled pin shows a high level");
   AST_RESET_PINS_IDLE: assert property ($rose(i_rst_b) |-> oe_bits == 4'hf && lvl == 4'h0 && !o_unit_b_irq_line)
      else $error("pins not idle after reset");
   AST_IRQ_MASKED: assert property (i_write && i_addr == 8'h0c && i_wdata[1:0] == 2'b00 |=> !o_unit_b_irq_line)
      else $error("interrupt stays high with all events masked");
   AST_IRQ_HAS_STATUS: assert property (i_read && i_addr == 8'h08 && o_unit_b_irq_line |=> o_rdata[1:0] != 2'b00)
      else $error("interrupt high without a status bit");
   AST_SOFT_UPDATE_PULSE: assert property (i_read && i_addr == 8'h00 |=> o_rdata[3:2] == 2'b00)
      else $error("soft update bits read back set");
endmodule // hbspwm_pair_properties
bind hbspwm_pair hbspwm_pair_properties u_props (.i_clock(i_clock), .i_rst_b(i_rst_b),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
   .o_unit_b_output_primary(o_unit_b_output_primary),
   .o_unit_b_output_complement(o_unit_b_output_complement),
   .o_unit_c_output_primary(o_unit_c_output_primary),
   .o_unit_c_output_complement(o_unit_c_output_complement),
   .o_unit_b_output_primary_oe_b(o_unit_b_output_primary_oe_b),
   .o_unit_b_output_complement_oe_b(o_unit_b_output_complement_oe_b),
   .o_unit_c_output_primary_oe_b(o_unit_c_output_primary_oe_b),
   .o_unit_c_output_complement_oe_b(o_unit_c_output_complement_oe_b),
   .o_unit_b_irq_line(o_unit_b_irq_line));

// File: hbspwm_gate_model.sv
// Gate driver model of the bridge power stage
`timescale 1ns/1ns
module hbspwm_gate_model (
   // Clock
   input logic i_clock,
   // Gate levels and enables: b primary, b complement, c primary, c complement
   input logic [3:0] i_gate,
   input logic [3:0] i_gate_oe_b,
   // Tally of cycles that would damage the stage
   output int o_fault_count
);
   initial o_fault_count = 0;
   // Real drivers would blow the leg, so just tally it for the bench
   always @(posedge i_clock) begin
      if ((i_gate[0] & i_gate[1]) | (i_gate[2] & i_gate[3]) | ((i_gate & i_gate_oe_b) != 4'h0))
         o_fault_count <= o_fault_count + 1;
   end
endmodule // hbspwm_gate_model

// File: hbspwm_pair_tb.sv
// Self-checking bench for the H-bridge PWM pair
`timescale 1ns/1ns
module hbspwm_pair_tb;
   localparam int P = 20;
   localparam int RISE = 2;
   localparam int FALL = 3;
   logic i_clock, i_rst_b, i_write, i_read;
   logic [7:0] i_addr;
   logic [31:0] i_wdata, rnd, d, e;
   wire [31:0] o_rdata;
   wire [3:0] gate, gate_oe_b;
   wire irq;
   int num_errors, total_checks, fault_count, a, b, k;
   hbspwm_pair u_dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
      .o_unit_b_output_primary(gate[0]), .o_unit_b_output_complement(gate[1]),
      .o_unit_c_output_primary(gate[2]), .o_unit_c_output_complement(gate[3]),
      .o_unit_b_output_primary_oe_b(gate_oe_b[0]),
      .o_unit_b_output_complement_oe_b(gate_oe_b[1]),
      .o_unit_c_output_primary_oe_b(gate_oe_b[2]),
      .o_unit_c_output_complement_oe_b(gate_oe_b[3]), .o_unit_b_irq_line(irq));
   hbspwm_gate_model u_gate (.i_clock(i_clock), .i_gate(gate), .i_gate_oe_b(gate_oe_b),
      .o_fault_count(fault_count));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // One-cycle strobes, launched just after an edge
   task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
      @(posedge i_clock);
      i_write <= 1'b1;
      i_addr <= ad;
      i_wdata <= wd;
      @(posedge i_clock);
      i_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad, output logic [31:0] rv);
      @(posedge i_clock);
      i_read <= 1'b1;
      i_addr <= ad;
      @(posedge i_clock);
      i_read <= 1'b0;
      #1 rv = o_rdata;
   endtask
   task automatic cfg(input logic [7:0] base, input logic [31:0] ctl, input int ca, input int cb);
      wr(base, ctl);
      wr(base + 8'h04, P);
      wr(base + 8'h08, ca);
      wr(base + 8'h0c, cb);
      wr(base + 8'h10, {16'(FALL), 16'(RISE)});
   endtask
   // High time over one full period, against the integer model
   task automatic meas(input int ca, input int cb, input int cc, input int cd, input bit dt);
      int h[4];
      int w[2];
      int ep, ec;
      h = '{0, 0, 0, 0};
      w = '{cb - ca, cd - cc};
      repeat (P + 1) begin
         @(posedge i_clock);
         #1;
         foreach (h[i]) h[i] += (gate[i] === 1'b1);
      end
      // Equal compares keep a leg static: only its low side on with dead time, both sides off without
      for (int u = 0; u < 2; u++) begin
         ep = (w[u] == 0) ? 0 : (dt ? w[u] - RISE - 1 : w[u]);
         ec = (w[u] == 0) ? (dt ? P + 1 : 0) : (dt ? P - w[u] - FALL : 0);
         chk("primary high", ep, h[2 * u]);
         chk("complement high", ec, h[2 * u + 1]);
      end
   endtask
   initial begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end
   initial begin
      i_rst_b = 1'b0;
      i_write = 1'b0;
      i_read = 1'b0;
      i_addr = 8'h00;
      i_wdata = 32'h0;
      num_errors = 0;
      total_checks = 0;
      rnd = 32'h4368;
      repeat (6) @(posedge i_clock);
      i_rst_b <= 1'b1;
      rd(8'h24, d);
      chk("period reset", 32'h0000ffff, d);
      rd(8'h20, d);
      chk("control reset", 32'h1, d);
      wr(8'h80, 32'hffffffff);
      rd(8'h80, d);
      chk("unmapped read", 32'h0, d);
      chk("pins after reset", 8'hf0, {gate_oe_b, gate});
      // Same setup on both units, loaded before counting starts
      cfg(8'h20, 32'hf, 5, 15);
      cfg(8'h40, 32'hf, 5, 15);
      wr(8'h00, 32'hc);
      wr(8'h04, 32'hf);
      wr(8'h0c, 32'h1);
      wr(8'h00, 32'h3);
      rd(8'h00, d);
      chk("master control", 32'h3, d);
      chk("pins enabled", 4'h0, gate_oe_b);
      rd(8'h20, d);
      rd(8'h40, e);
      chk("unit c counter phase", (d[31:16] + 2) % (P + 1), e[31:16]);
      // Random duties, with and without dead time, taken at the wrap
      for (k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         a = 2 + rnd[1:0];
         b = 12 + rnd[4:2];
         cfg(8'h20, k[0] ? 32'h7 : 32'hf, a, b);
         cfg(8'h40, k[0] ? 32'h7 : 32'hf, a, b);
         repeat (2 * (P + 1)) @(posedge i_clock);
         meas(a, b, a, b, !k[0]);
      end
      // Half-line legs: one unit switches, the other holds its low side on
      cfg(8'h20, 32'hf, 5, 15);
      cfg(8'h40, 32'hf, 0, 0);
      repeat (2 * (P + 1)) @(posedge i_clock);
      meas(5, 15, 0, 0, 1'b1);
      cfg(8'h20, 32'hf, 0, 0);
      cfg(8'h40, 32'hf, 5, 15);
      repeat (2 * (P + 1)) @(posedge i_clock);
      meas(0, 0, 5, 15, 1'b1);
      // Without update at the wrap, a new compare waits for a soft update
      cfg(8'h20, 32'hf, 5, 15);
      cfg(8'h40, 32'hf, 5, 15);
      repeat (2 * (P + 1)) @(posedge i_clock);
      wr(8'h20, 32'hb);
      wr(8'h40, 32'hb);
      wr(8'h2c, 32'd18);
      wr(8'h4c, 32'd18);
      repeat (2 * (P + 1)) @(posedge i_clock);
      meas(5, 15, 5, 15, 1'b1);
      wr(8'h00, 32'hf);
      repeat (P + 1) @(posedge i_clock);
      meas(5, 18, 5, 18, 1'b1);
      // Interrupt: raised, masked, unmasked, cleared
      for (k = 0; k < 3 * P && irq !== 1'b1; k++) @(posedge i_clock);
      chk("irq raised", 1'b1, irq);
      if (irq !== 1'b1) end_sim;
      rd(8'h08, d);
      chk("irq status", 32'h1, d & 32'h1);
      wr(8'h0c, 32'h0);
      #1 chk("irq masked", 1'b0, irq);
      wr(8'h0c, 32'h1);
      #1 chk("irq unmasked", 1'b1, irq);
      wr(8'h00, 32'h0);
      wr(8'h08, 32'h3);
      rd(8'h08, d);
      chk("status cleared", 32'h0, d);
      chk("irq cleared", 1'b0, irq);
      wr(8'h04, 32'h0);
      #1 chk("pins disabled", 8'hf0, {gate_oe_b, gate});
      chk("gate faults", 32'h0, fault_count);
      end_sim;
   end
endmodule // hbspwm_pair_tb
